// ==== bus_matrix_config_params.svh ====
// What this block does
// RL1: one 4 GB address space; every region has a unique 32-bit physical address
// RL2: CPU presents virtual addresses; bus-master peripherals present physical addresses
// RL3: cached kernel window is cacheable; uncached kernel alias is non-cacheable
// RL4: bit 20 enables unmapped-access bus errors from the shared peripheral bus
// RL5: bit 19 enables unmapped-access bus errors from the debug unit
// RL6: bit 18 enables unmapped-access bus errors from the DMA engine
// RL7: bit 17 enables CPU data unmapped bus errors; no effect in debug mode
// RL8: bit 16 enables CPU fetch unmapped bus errors; disabled in debug mode
// RL9: bit 6 adds one address-setup wait state to CPU data RAM accesses
// RL10: bits 2..0 select arbitration mode 0, 1 (reset default) or 2
// RL11: software never writes reserved arbitration codes 011 through 111
// RL12: unimplemented configuration bits read zero and ignore writes
// RL13: arbitration and wait changes apply from the next transaction start
//
// Purpose: offsets, field positions, reset values for the bus matrix configuration
// Assumes: 32-bit register port, word offsets
// Notes:   included by bare name
`ifndef BUS_MATRIX_CONFIG_PARAMS_SVH
`define BUS_MATRIX_CONFIG_PARAMS_SVH

`define BMC_OFS_CONFIG        8'h00
`define BMC_OFS_ERR_STATUS    8'h04
`define BMC_OFS_ERR_MASK      8'h08

`define BMC_CFG_RESET         32'h001F0041
`define BMC_CFG_WRITABLE      32'h001F0047
`define BMC_BIT_ERR_FETCH     16
`define BMC_BIT_ERR_SPB       20
`define BMC_BIT_WAIT          6
`define BMC_ARB_LSB           0
`define BMC_ARB_MSB           2

`define BMC_ERR_RESET         5'h00
`define BMC_MASK_RESET        5'h00

`define BMC_WIN_CACHED        3'h4
`define BMC_WIN_UNCACHED      3'h5
`define BMC_KSEG_PHYS_MASK    32'h1FFFFFFF
`define BMC_USER_OFFSET       32'h40000000

`endif

// ==== bus_matrix_config_pkg.sv ====
// Purpose: shared types of the bus matrix configuration block
// Assumes: nothing
// Notes:   constants live in the params header
package bus_matrix_config_pkg;

	typedef enum logic [2:0] {
		ARB_MODE_0 = 3'h0,
		ARB_MODE_1 = 3'h1,
		ARB_MODE_2 = 3'h2
	} arb_policy_e;

	typedef enum logic [1:0] {
		WIN_USER,
		WIN_CACHED,
		WIN_UNCACHED,
		WIN_OTHER
	} addr_window_e;

	typedef enum {
		RAM_IDLE,
		RAM_SETUP
	} ram_state_e;

	typedef logic [4:0] initiator_vec_t;

endpackage

// ==== bus_matrix_config.sv ====
// Purpose: configuration, error policy and address windows of the system bus matrix
// Assumes: one clock, inputs synchronous, register port strobes one cycle long
// Notes:   initiator index 0 fetch, 1 cpu data, 2 dma, 3 debug unit, 4 shared bus
//
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/10ps
`include "bus_matrix_config_params.svh"

module bus_matrix_config #(
	parameter int          N_INIT      = 5,
	parameter logic [31:0] USER_OFFSET = `BMC_USER_OFFSET
) (
	input  wire logic              core_clk_i,
	input  wire logic              reset_i,
	// register port
	input  wire logic [7:0]        reg_addr_i,
	input  wire logic [31:0]       reg_wdata_i,
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	output logic      [31:0]       reg_rdata_o,
	// matrix status
	input  wire logic              txn_start_i,
	input  wire logic              cpu_debug_mode_i,
	input  wire logic [N_INIT-1:0] unmapped_i,
	output logic      [N_INIT-1:0] bus_err_o,
	output logic      [2:0]        arb_mode_o,
	output logic                   irq_o,
	// cpu virtual address translation
	input  wire logic              cpu_vaddr_valid_i,
	input  wire logic [31:0]       cpu_vaddr_i,
	output logic                   cpu_paddr_valid_o,
	output logic      [31:0]       cpu_paddr_o,
	output logic                   cpu_cacheable_o,
	// bus-master physical address path
	input  wire logic              master_valid_i,
	input  wire logic [31:0]       master_paddr_i,
	output logic                   master_valid_o,
	output logic      [31:0]       master_paddr_o,
	// cpu data ram access timing
	input  wire logic              cpu_ram_req_i,
	output logic                   ram_setup_o,
	output logic                   ram_grant_o
);

	// window decode, shared by translation and cacheability
	function automatic bus_matrix_config_pkg::addr_window_e win_of(input logic [31:0] va);
		if (va[31] == 1'b0) begin
			win_of = bus_matrix_config_pkg::WIN_USER;
		end else if (va[31:29] == `BMC_WIN_CACHED) begin
			win_of = bus_matrix_config_pkg::WIN_CACHED;
		end else if (va[31:29] == `BMC_WIN_UNCACHED) begin
			win_of = bus_matrix_config_pkg::WIN_UNCACHED;
		end else begin
			win_of = bus_matrix_config_pkg::WIN_OTHER;
		end
	endfunction

	// register state
	logic [31:0]                          cfg_q;
	logic [31:0]                          cfg_d;
	logic [N_INIT-1:0]                    err_status_q;
	logic [N_INIT-1:0]                    err_status_d;
	logic [N_INIT-1:0]                    err_mask_q;
	logic [N_INIT-1:0]                    err_mask_d;
	logic [31:0]                          rdata_d;
	logic                                 eff_wait_q;
	logic                                 irq_d;
	bus_matrix_config_pkg::ram_state_e    ram_state_q;
	bus_matrix_config_pkg::ram_state_e    ram_state_d;

	// address decode of the register port
	wire logic                            sel_cfg;
	wire logic                            sel_status;
	wire logic                            sel_mask;
	assign sel_cfg    = (reg_addr_i == `BMC_OFS_CONFIG);
	assign sel_status = (reg_addr_i == `BMC_OFS_ERR_STATUS);
	assign sel_mask   = (reg_addr_i == `BMC_OFS_ERR_MASK);

	// only implemented bits take a write; the rest stay zero
	assign cfg_d = (reg_wr_i && sel_cfg) ?
		(reg_wdata_i & `BMC_CFG_WRITABLE) : cfg_q; // [RL12]
	assign err_mask_d = (reg_wr_i && sel_mask) ? reg_wdata_i[N_INIT-1:0] : err_mask_q;

	// read mux; unmapped offsets read zero
	assign rdata_d = !reg_rd_i ? 32'h00000000 :
		sel_cfg    ? cfg_q : // [RL12]
		sel_status ? {{(32-N_INIT){1'b0}}, err_status_q} :
		sel_mask   ? {{(32-N_INIT){1'b0}}, err_mask_q} :
		32'h00000000;

	// field views of the configuration word
	wire logic [N_INIT-1:0]               err_en;
	wire logic                            wait_en;
	wire logic [2:0]                      arb_sel;
	assign err_en  = cfg_q[`BMC_BIT_ERR_SPB:`BMC_BIT_ERR_FETCH];
	assign wait_en = cfg_q[`BMC_BIT_WAIT];
	assign arb_sel = cfg_q[`BMC_ARB_MSB:`BMC_ARB_LSB]; // [RL10]

	// per-initiator error gating; cpu ports are quiet in debug mode
	wire logic [N_INIT-1:0]               err_fire;
	genvar gi;
	generate
		for (gi = 0; gi < N_INIT; gi++) begin : g_err
			if (gi < 2) begin : g_cpu
				assign err_fire[gi] = unmapped_i[gi] & err_en[gi] & ~cpu_debug_mode_i; // [RL7] [RL8]
			end else begin : g_master
				assign err_fire[gi] = unmapped_i[gi] & err_en[gi]; // [RL4] [RL5] [RL6]
			end
		end
	endgenerate

	// sticky status: a new error wins over a write-one clear in the same cycle
	wire logic [N_INIT-1:0]               err_clr;
	assign err_clr      = (reg_wr_i && sel_status) ? reg_wdata_i[N_INIT-1:0] : '0;
	assign err_status_d = (err_status_q & ~err_clr) | err_fire;
	assign irq_d        = |(err_status_d & err_mask_d);

	// register file and event flops
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			cfg_q        <= `BMC_CFG_RESET;
			err_status_q <= `BMC_ERR_RESET;
			err_mask_q   <= `BMC_MASK_RESET;
			reg_rdata_o  <= 32'h00000000;
			bus_err_o    <= '0;
			irq_o        <= 1'b0;
		end else begin
			cfg_q        <= cfg_d;
			err_status_q <= err_status_d;
			err_mask_q   <= err_mask_d;
			reg_rdata_o  <= rdata_d;
			bus_err_o    <= err_fire;
			irq_o        <= irq_d;
		end
	end

	// effective settings move only at a transaction start, so a running
	// transaction never sees its arbitration or timing change under it
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			arb_mode_o <= bus_matrix_config_pkg::ARB_MODE_1;
			eff_wait_q <= 1'b1;
		end else if (txn_start_i) begin
			arb_mode_o <= arb_sel; // [RL13]
			eff_wait_q <= wait_en; // [RL13]
		end
	end

	// virtual to physical translation for the cpu
	bus_matrix_config_pkg::addr_window_e  cpu_win;
	wire logic [31:0]                     paddr_d;
	wire logic                            cache_d;
	assign cpu_win = win_of(cpu_vaddr_i);
	assign paddr_d =
		(cpu_win == bus_matrix_config_pkg::WIN_USER) ? (cpu_vaddr_i + USER_OFFSET) : // [RL2]
		(cpu_win == bus_matrix_config_pkg::WIN_OTHER) ? cpu_vaddr_i :
		(cpu_vaddr_i & `BMC_KSEG_PHYS_MASK); // [RL1] [RL3]
	// both kernel windows alias one resource; only the first is cacheable
	assign cache_d = (cpu_win == bus_matrix_config_pkg::WIN_CACHED) ||
		(cpu_win == bus_matrix_config_pkg::WIN_USER); // [RL3]

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			cpu_paddr_valid_o <= 1'b0;
			cpu_paddr_o       <= 32'h00000000;
			cpu_cacheable_o   <= 1'b0;
		end else begin
			cpu_paddr_valid_o <= cpu_vaddr_valid_i;
			cpu_paddr_o       <= cpu_vaddr_valid_i ? paddr_d : cpu_paddr_o;
			cpu_cacheable_o   <= cpu_vaddr_valid_i & cache_d;
		end
	end

	// bus masters already speak physical addresses: no translation, one flop of delay
	// kept so both paths reach the matrix with the same latency
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			master_valid_o <= 1'b0;
			master_paddr_o <= 32'h00000000;
		end else begin
			master_valid_o <= master_valid_i;
			master_paddr_o <= master_valid_i ? master_paddr_i : master_paddr_o; // [RL2]
		end
	end

	// data ram setup wait: one stall cycle before the grant when enabled
	wire logic                            setup_d;
	wire logic                            grant_d;
	always_comb begin
		ram_state_d = ram_state_q;
		case (ram_state_q)
			bus_matrix_config_pkg::RAM_IDLE: begin
				if (cpu_ram_req_i && eff_wait_q) begin
					ram_state_d = bus_matrix_config_pkg::RAM_SETUP; // [RL9]
				end
			end
			bus_matrix_config_pkg::RAM_SETUP: begin
				ram_state_d = bus_matrix_config_pkg::RAM_IDLE;
			end
			default: begin
				ram_state_d = bus_matrix_config_pkg::RAM_IDLE;
			end
		endcase
	end
	assign setup_d = (ram_state_q == bus_matrix_config_pkg::RAM_IDLE) && cpu_ram_req_i &&
		eff_wait_q;
	assign grant_d = ((ram_state_q == bus_matrix_config_pkg::RAM_IDLE) && cpu_ram_req_i &&
		!eff_wait_q) || (ram_state_q == bus_matrix_config_pkg::RAM_SETUP); // [RL9]

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			ram_state_q <= bus_matrix_config_pkg::RAM_IDLE;
			ram_setup_o <= 1'b0;
			ram_grant_o <= 1'b0;
		end else begin
			ram_state_q <= ram_state_d;
			ram_setup_o <= setup_d;
			ram_grant_o <= grant_d;
		end
	end

	// checks beside the logic they guard
	AST_SPB_ERR: assert property (@(posedge core_clk_i) disable iff (reset_i) // [RL4]
		unmapped_i[4] && err_en[4] |=> bus_err_o[4])
		else $error("shared bus unmapped access gave no bus error");

	AST_DBG_SUPPRESS: assert property (@(posedge core_clk_i) disable iff (reset_i) // [RL5]
		unmapped_i[3] && !err_en[3] |=> !bus_err_o[3])
		else $error("debug unit error raised while disabled");

	AST_DMA_ERR: assert property (@(posedge core_clk_i) disable iff (reset_i) // [RL6]
		bus_err_o[2] |-> $past(unmapped_i[2]) && $past(err_en[2]))
		else $error("dma bus error without enabled unmapped access");

	AST_DATA_DEBUG: assert property (@(posedge core_clk_i) disable iff (reset_i) // [RL7]
		cpu_debug_mode_i |=> !bus_err_o[1])
		else $error("cpu data bus error raised in debug mode");

	AST_FETCH_ERR: assert property (@(posedge core_clk_i) disable iff (reset_i) // [RL8]
		unmapped_i[0] && err_en[0] && !cpu_debug_mode_i |=> bus_err_o[0])
		else $error("cpu fetch unmapped access gave no bus error");

	AST_WAIT_SETUP: assert property (@(posedge core_clk_i) disable iff (reset_i) // [RL9]
		(ram_state_q == bus_matrix_config_pkg::RAM_IDLE) && cpu_ram_req_i && eff_wait_q
		|=> ram_setup_o && !ram_grant_o ##1 ram_grant_o && !ram_setup_o)
		else $error("data ram wait state not one setup cycle");

	AST_NO_WAIT: assert property (@(posedge core_clk_i) disable iff (reset_i) // [RL9]
		(ram_state_q == bus_matrix_config_pkg::RAM_IDLE) && cpu_ram_req_i && !eff_wait_q
		|=> ram_grant_o && !ram_setup_o)
		else $error("data ram access stalled with wait disabled");

	AST_RSVD_ZERO: assert property (@(posedge core_clk_i) disable iff (reset_i) // [RL12]
		reg_rd_i && sel_cfg |=> (reg_rdata_o & ~`BMC_CFG_WRITABLE) == 32'h00000000)
		else $error("unimplemented configuration bits read nonzero");

	// a write keeps only the implemented bits of the configuration word
	AST_CFG_WRITE: assert property (@(posedge core_clk_i) disable iff (reset_i) // [RL12]
		reg_wr_i && sel_cfg |=> cfg_q == ($past(reg_wdata_i) & `BMC_CFG_WRITABLE))
		else $error("configuration write stored unimplemented bits");

	// an error event always lands in status, even beside a write-one clear
	AST_STATUS_STICKY: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(err_fire != '0) |=> (err_status_q & $past(err_fire)) == $past(err_fire))
		else $error("error event lost from sticky status");

	AST_ARB_HOLD: assert property (@(posedge core_clk_i) disable iff (reset_i) // [RL13]
		!txn_start_i |=> $stable(arb_mode_o) && $stable(eff_wait_q))
		else $error("effective settings changed outside a transaction start");

	AST_ARB_TAKE: assert property (@(posedge core_clk_i) disable iff (reset_i) // [RL10]
		txn_start_i |=> arb_mode_o == $past(arb_sel))
		else $error("arbitration mode not taken at transaction start");

	AST_UNCACHED: assert property (@(posedge core_clk_i) disable iff (reset_i) // [RL3]
		cpu_vaddr_valid_i && cpu_vaddr_i[31:29] == `BMC_WIN_UNCACHED
		|=> cpu_paddr_valid_o && !cpu_cacheable_o &&
		cpu_paddr_o == ($past(cpu_vaddr_i) & `BMC_KSEG_PHYS_MASK))
		else $error("uncached kernel window decoded wrongly");

	AST_IRQ_LEVEL: assert property (@(posedge core_clk_i) disable iff (reset_i)
		irq_o == |(err_status_q & err_mask_q))
		else $error("interrupt output disagrees with masked status");

endmodule // bus_matrix_config

// ==== bus_matrix_far_side.sv ====
// Purpose: model of the initiators beyond the bus matrix: unmapped hits, starts, addresses
// Assumes: requests change just after a rising edge and last exactly one cycle
// Notes:   the bench calls its tasks; released address lines show the inverted value
`timescale 1ns/10ps

module bus_matrix_far_side (
	input  wire logic        core_clk_i,
	output logic      [4:0]  unmapped_o,
	output logic             txn_start_o,
	output logic             ram_req_o,
	output logic             cpu_vaddr_valid_o,
	output logic      [31:0] cpu_vaddr_o,
	output logic             master_valid_o,
	output logic      [31:0] master_paddr_o
);
	// idle state at time zero
	initial begin
		unmapped_o = 5'h00;
		txn_start_o = 1'b0;
		ram_req_o = 1'b0;
		cpu_vaddr_valid_o = 1'b0;
		cpu_vaddr_o = 32'h00000000;
		master_valid_o = 1'b0;
		master_paddr_o = 32'h00000000;
	end

	// any subset of initiators lands in unmapped space for one cycle
	task automatic hit_unmapped(input logic [4:0] who);
		@(posedge core_clk_i);
		unmapped_o <= who;
		@(posedge core_clk_i);
		unmapped_o <= 5'h00;
	endtask

	// a matrix transaction begins
	task automatic start_txn();
		@(posedge core_clk_i);
		txn_start_o <= 1'b1;
		@(posedge core_clk_i);
		txn_start_o <= 1'b0;
	endtask

	// cpu asks for data ram; the bench waits for the grant before asking again
	task automatic ram_access();
		@(posedge core_clk_i);
		ram_req_o <= 1'b1;
		@(posedge core_clk_i);
		ram_req_o <= 1'b0;
	endtask

	// cpu gives a virtual address, a dma master a physical one
	task automatic present_addr(input logic [31:0] va, input logic [31:0] pa);
		@(posedge core_clk_i);
		cpu_vaddr_valid_o <= 1'b1;
		cpu_vaddr_o <= va;
		master_valid_o <= 1'b1;
		master_paddr_o <= pa;
		@(posedge core_clk_i);
		cpu_vaddr_valid_o <= 1'b0;
		cpu_vaddr_o <= ~va;
		master_valid_o <= 1'b0;
		master_paddr_o <= ~pa;
	endtask
endmodule // bus_matrix_far_side

// ==== bus_matrix_config_tb_top.sv ====
// Purpose: self-checking bench of the bus matrix configuration block
// Assumes: fixed latencies of one or two cycles, so no wait needs polling
// Notes:   a watchdog cuts the run short if the sequence ever stalls
`timescale 1ns/10ps
`include "bus_matrix_config_params.svh"

module bus_matrix_config_tb_top;
	logic        core_clk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic [7:0]  reg_addr_i = 8'h00;
	logic [31:0] reg_wdata_i = 32'h00000000;
	logic        reg_wr_i = 1'b0;
	logic        reg_rd_i = 1'b0;
	logic        cpu_debug_mode_i = 1'b0;
	logic [31:0] reg_rdata_o, cpu_paddr_o, master_paddr_o, cpu_vaddr_i, master_paddr_i, rd;
	logic [4:0]  unmapped_i, bus_err_o;
	logic [2:0]  arb_mode_o;
	logic        irq_o, cpu_paddr_valid_o, cpu_cacheable_o, master_valid_o, ram_setup_o;
	logic        ram_grant_o, txn_start_i, cpu_vaddr_valid_i, master_valid_i, cpu_ram_req_i;
	int          errors = 0;
	int          checks_done = 0;

	bus_matrix_config uut (.core_clk_i(core_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .txn_start_i(txn_start_i),
		.cpu_debug_mode_i(cpu_debug_mode_i), .unmapped_i(unmapped_i), .bus_err_o(bus_err_o),
		.arb_mode_o(arb_mode_o), .irq_o(irq_o), .cpu_vaddr_valid_i(cpu_vaddr_valid_i),
		.cpu_vaddr_i(cpu_vaddr_i), .cpu_paddr_valid_o(cpu_paddr_valid_o),
		.cpu_paddr_o(cpu_paddr_o), .cpu_cacheable_o(cpu_cacheable_o),
		.master_valid_i(master_valid_i), .master_paddr_i(master_paddr_i),
		.master_valid_o(master_valid_o), .master_paddr_o(master_paddr_o),
		.cpu_ram_req_i(cpu_ram_req_i), .ram_setup_o(ram_setup_o), .ram_grant_o(ram_grant_o));

	bus_matrix_far_side far (.core_clk_i(core_clk_i), .unmapped_o(unmapped_i),
		.txn_start_o(txn_start_i), .ram_req_o(cpu_ram_req_i),
		.cpu_vaddr_valid_o(cpu_vaddr_valid_i), .cpu_vaddr_o(cpu_vaddr_i),
		.master_valid_o(master_valid_i), .master_paddr_o(master_paddr_i));

	// 100 MHz clock
	always #5 core_clk_i = ~core_clk_i;

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe, so sample just past that edge
	task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge core_clk_i);
		reg_rd_i <= 1'b0;
		#1 d = reg_rdata_o;
	endtask

	task automatic t_reset_and_reserved();
		reg_read(`BMC_OFS_CONFIG, rd);
		check(rd, 32'h001F0041);
		check({29'h0, arb_mode_o}, 32'h00000001);
		reg_write(`BMC_OFS_CONFIG, 32'hFFFFFFFA); // arbitration code kept legal
		reg_read(`BMC_OFS_CONFIG, rd);
		check(rd, 32'h001F0042);
		reg_read(8'h0C, rd);
		check(rd, 32'h00000000);
		$display("test reset_and_reserved done");
	endtask

	task automatic t_error_enables();
		for (int i = 0; i < 5; i++) begin
			reg_write(`BMC_OFS_CONFIG, (32'h00000001 << (16 + i)) | 32'h00000001);
			far.hit_unmapped(5'h1F);
			#1 check({27'h0, bus_err_o}, 32'h00000001 << i);
		end
		reg_write(`BMC_OFS_CONFIG, 32'h00000001);
		far.hit_unmapped(5'h1F);
		#1 check({27'h0, bus_err_o}, 32'h00000000);
		reg_write(`BMC_OFS_CONFIG, 32'h001F0041);
		cpu_debug_mode_i <= 1'b1;
		far.hit_unmapped(5'h1F);
		#1 check({27'h0, bus_err_o}, 32'h0000001C);
		@(posedge core_clk_i);
		cpu_debug_mode_i <= 1'b0;
		$display("test error_enables done");
	endtask

	// status is sticky and write-one-to-clear; only masked-in bits raise the line
	task automatic t_interrupt();
		// earlier scenarios left status bits set; start from a clean status
		reg_write(`BMC_OFS_ERR_STATUS, 32'h0000001F);
		reg_write(`BMC_OFS_ERR_MASK, 32'h00000004);
		#1 check({31'h0, irq_o}, 32'h00000000);
		far.hit_unmapped(5'h04);
		#1 check({31'h0, irq_o}, 32'h00000001);
		reg_write(`BMC_OFS_ERR_STATUS, 32'h00000004);
		@(posedge core_clk_i);
		#1 check({31'h0, irq_o}, 32'h00000000);
		far.hit_unmapped(5'h08);
		#1 check({31'h0, irq_o}, 32'h00000000);
		reg_read(`BMC_OFS_ERR_STATUS, rd);
		check(rd, 32'h00000008);
		reg_write(`BMC_OFS_ERR_STATUS, 32'h0000001F);
		$display("test interrupt done");
	endtask

	// a new mode waits for the next transaction start
	task automatic t_arbitration();
		logic [2:0] codes [3] = '{3'h2, 3'h0, 3'h1}; // reserved codes never written
		logic [2:0] prev;
		prev = arb_mode_o;
		foreach (codes[k]) begin
			reg_write(`BMC_OFS_CONFIG, 32'h001F0040 | {29'h0, codes[k]});
			@(posedge core_clk_i);
			#1 check({29'h0, arb_mode_o}, {29'h0, prev});
			far.start_txn();
			#1 check({29'h0, arb_mode_o}, {29'h0, codes[k]});
			prev = codes[k];
		end
		$display("test arbitration done");
	endtask

	task automatic t_ram_wait();
		far.ram_access();
		#1 check({30'h0, ram_setup_o, ram_grant_o}, 32'h00000002);
		@(posedge core_clk_i);
		#1 check({30'h0, ram_setup_o, ram_grant_o}, 32'h00000001);
		reg_write(`BMC_OFS_CONFIG, 32'h001F0001);
		far.ram_access();
		#1 check({30'h0, ram_setup_o, ram_grant_o}, 32'h00000002);
		@(posedge core_clk_i);
		far.start_txn();
		far.ram_access();
		#1 check({30'h0, ram_setup_o, ram_grant_o}, 32'h00000001);
		$display("test ram_wait done");
	endtask

	task automatic t_addresses();
		logic [31:0] va [3] = '{32'hA0001000, 32'h80001000, 32'h00000100};
		logic [31:0] pa [3] = '{32'h00001000, 32'h00001000, 32'h40000100};
		logic        ca [3] = '{1'b0, 1'b1, 1'b1};
		foreach (va[k]) begin
			far.present_addr(va[k], 32'h1D000000 + k);
			#1 check(cpu_paddr_o, pa[k]);
			check({30'h0, cpu_paddr_valid_o, cpu_cacheable_o}, {30'h1, ca[k]});
			check(master_paddr_o, 32'h1D000000 + k);
			check({31'h0, master_valid_o}, 32'h00000001);
		end
		$display("test addresses done");
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// main sequence; the wait bit starts set, so ram scenarios follow the reset value
	initial begin
		repeat (3) @(posedge core_clk_i);
		reset_i <= 1'b0;
		t_reset_and_reserved();
		reg_write(`BMC_OFS_CONFIG, 32'h001F0041);
		far.start_txn();
		t_ram_wait();
		t_error_enables();
		t_interrupt();
		t_arbitration();
		t_addresses();
		final_report();
	end

	// watchdog
	initial begin
		repeat (20000) @(posedge core_clk_i);
		errors++;
		final_report();
	end
endmodule // bus_matrix_config_tb_top
